/* File: hw/tvf_i2c_regs.sv */
// tvf tuner and IF two-address I2C slave register bank
//
// Summary of operation
// - tuner write: address, divider, control, band bytes acked
// - tuner address C0..C6 from select bits
// - floating address select answers at C2
// - divider ratio is binary weighted, 8192 down
// - pump select 0 low, 1 high current
// - test bits 011 put auxiliary byte after control
// - step select picks 50/31.25/166.7/62.5 kHz
// - band byte decodes low/mid/high, FM, mono
// - auxiliary time bit: 0 slow, 1 fast AGC
// - three takeover bits pick IF output level
// - takeover field resets to 010
// - tuner read repeats the status byte while the master acks
// - power-up flag reads 1 after power-on
// - lock after 8 locked reference periods
// - AGC status bit shows internal AGC active
// - stereo bits 100 stereo, top 0 mono
// - IF write: address, subaddress, data, acked; 86/84
// - subaddress 0..2 with auto-increment, bit7 refused
// - switching register fields drive IF switching
// - adjust register: gain, de-emphasis, takeover
// - data register: VIF AGC, gating, IF gain
// - data register picks video IF, sound carrier
`timescale 1ns/100ps
module tvf_i2c_regs
    import tvf_pkg::*;
(
    input  wire logic           mclk,
    input  wire logic           resetn,
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe,
    input  wire logic [1:0]     address_select_bits,
    input  wire logic           address_select_float,
    input  wire logic           if_address_alt,
    input  wire logic           pll_phase_locked,
    input  wire logic           agc_active,
    input  wire logic           fm_stereo_detect,
    output logic      [13:0]    divider_ratio,
    output logic                pump_current_select,
    output logic      [2:0]     test_mode_bits,
    output logic      [1:0]     step_size_select,
    output logic                pll_disable,
    output logic      [7:0]     band_port_bits,
    output tvf_band_s           band_decode,
    output logic                agc_time_select,
    output logic      [2:0]     agc_takeover_level,
    output tvf_if_switch_s      if_switching,
    output tvf_if_adjust_s      if_adjust,
    output tvf_if_data_s        if_data,
    output logic                lock_indicator,
    output logic                power_up_flag
);
    localparam logic [10:0] REF_LAST = 11'(REF_CYC - 1);

    tvf_state_s q;
    tvf_state_s d;
    logic [7:0] s_vec;
    logic       s_scl;
    logic       s_sda;
    logic [1:0] s_sel;
    logic       s_float;
    logic       s_alt;
    logic       s_locked;
    logic       s_agc;
    logic       s_stereo;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       ref_tick;
    logic [1:0] sel_bits;
    logic [7:0] tuner_addr;
    logic [7:0] if_addr;
    logic [7:0] status_byte;

    // every pin and analogue flag passes two flops first
    tvf_sync #(.W(8)) u_sync (
        .mclk    (mclk),
        .resetn  (resetn),
        .d_async ({scl_in, sda_in, address_select_bits, address_select_float,
                   if_address_alt, pll_phase_locked, agc_active}),
        .q_sync  (s_vec)
    );

    tvf_sync #(.W(1)) u_sync_st (
        .mclk    (mclk),
        .resetn  (resetn),
        .d_async (fm_stereo_detect),
        .q_sync  (s_stereo)
    );

    assign {s_scl, s_sda, s_sel, s_float, s_alt, s_locked, s_agc} = s_vec;

    // bus events seen on the synchronised lines
    assign scl_rise  = s_scl & ~q.scl_p;
    assign scl_fall  = ~s_scl & q.scl_p;
    assign bus_start = s_scl & q.scl_p & q.sda_p & ~s_sda;
    assign bus_stop  = s_scl & q.scl_p & ~q.sda_p & s_sda;
    assign ref_tick  = (q.ref_cnt == REF_LAST);

    // slave addresses from the select inputs
    assign sel_bits    = s_float ? ADDR_SEL_FLOAT : s_sel;
    assign tuner_addr  = TUNER_ADDR_BASE | {5'h00, sel_bits, 1'b0};
    assign if_addr     = s_alt ? IF_ADDR_ALTERNATE : IF_ADDR_DEFAULT;

    // status byte: power-up, lock, two ones, AGC, stereo
    assign status_byte = {q.por, q.lock, STATUS_ONES, s_agc,
                          s_stereo ? STEREO_IND_STEREO : STEREO_IND_MONO};

    // next-state logic
    always_comb begin
        logic ack_now;
        ack_now = 1'b0;
        d       = q;
        d.scl_p = s_scl;
        d.sda_p = s_sda;

        // reference divider and lock qualification
        d.ref_cnt = ref_tick ? 11'h000 : q.ref_cnt + 11'h001;
        if (!s_locked) begin
            d.lock_cnt = 4'h0;
        end else if (ref_tick && q.lock_cnt != LOCK_PERIODS) begin
            d.lock_cnt = q.lock_cnt + 4'h1;
        end
        d.lock = s_locked && (d.lock_cnt == LOCK_PERIODS);

        if (bus_start) begin
            d.st     = ST_ADDR;
            d.cnt    = 4'h0;
            d.pos    = POS_DIV_HIGH;
            d.sda_oe = 1'b0;
        end else if (bus_stop) begin
            d.st     = ST_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    d.sda_oe = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        d.sh  = {q.sh[6:0], s_sda};
                        d.cnt = q.cnt + 4'h1;
                    end else if (scl_fall && q.cnt == 4'h8) begin
                        d.cnt = 4'h0;
                        if (q.st == ST_ADDR) begin
                            // address byte: pick the section
                            if (q.sh[7:1] == tuner_addr[7:1]) begin
                                d.tgt   = TGT_TUNER;
                                d.rw    = q.sh[0];
                                ack_now = 1'b1;
                            end else if (q.sh[7:1] == if_addr[7:1] && !q.sh[0]) begin
                                d.tgt   = TGT_IF;
                                d.rw    = 1'b0;
                                ack_now = 1'b1;
                            end
                        end else if (q.tgt == TGT_TUNER) begin
                            // each byte commits on its own ack
                            ack_now = 1'b1;
                            unique case (q.pos)
                                POS_DIV_HIGH: d.div_high = q.sh;
                                POS_DIV_LOW:  d.div_low  = q.sh;
                                POS_CONTROL:  d.control  = q.sh;
                                POS_BAND_OR_AUX: begin
                                    if (q.control[CTRL_TEST_MSB:CTRL_TEST_LSB] == TEST_AUX_FOLLOWS) begin
                                        d.aux = q.sh;
                                    end else begin
                                        d.band = q.sh;
                                        d.band_dec.tv_low  = q.sh[BAND_LOW_BIT] & ~q.sh[BAND_FM_B_BIT];
                                        d.band_dec.tv_mid  = q.sh[BAND_MID_BIT];
                                        d.band_dec.tv_high = q.sh[BAND_HIGH_BIT];
                                        d.band_dec.fm_band = q.sh[BAND_FM_B_BIT] & q.sh[BAND_FM_A_BIT]
                                                             & q.sh[BAND_LOW_BIT];
                                        d.band_dec.fm_mono = q.sh[BAND_FM_B_BIT] & q.sh[BAND_FM_A_BIT]
                                                             & q.sh[BAND_LOW_BIT] & q.sh[BAND_MONO_BIT];
                                    end
                                end
                                default: ;
                            endcase
                            if (q.pos != POS_DONE) begin
                                d.pos = q.pos + 3'h1;
                            end
                        end else begin
                            // IF section: subaddress, then auto-increment
                            if (q.pos == POS_DIV_HIGH) begin
                                if (!q.sh[IF_SUB_FORBID_BIT]) begin
                                    d.ptr   = q.sh[1:0];
                                    d.pos   = POS_DIV_LOW;
                                    ack_now = 1'b1;
                                end
                            end else begin
                                ack_now = 1'b1;
                                unique case (q.ptr)
                                    IF_SUB_SWITCHING: d.if_sw  = q.sh;
                                    IF_SUB_ADJUST:    d.if_adj = q.sh;
                                    IF_SUB_DATA:      d.if_dat = q.sh;
                                    default: ;
                                endcase
                                if (q.ptr != 2'h3) begin
                                    d.ptr = q.ptr + 2'h1;
                                end
                            end
                        end
                        d.sda_oe = ack_now;
                        d.st     = ack_now ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (q.rw) begin
                            d.sh     = status_byte;
                            d.sda_oe = ~status_byte[7];
                            d.cnt    = 4'h1;
                            d.st     = ST_TX;
                        end else begin
                            d.sda_oe = 1'b0;
                            d.st     = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (q.cnt == 4'h8) begin
                            d.sda_oe = 1'b0;
                            d.st     = ST_TX_ACK;
                            d.por    = 1'b0;
                        end else begin
                            d.sh     = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                            d.cnt    = q.cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        d.m_ack = ~s_sda;
                    end else if (scl_fall) begin
                        if (q.m_ack) begin
                            d.sh     = status_byte;
                            d.sda_oe = ~status_byte[7];
                            d.cnt    = 4'h1;
                            d.st     = ST_TX;
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q          <= '0;
            q.st       <= ST_IDLE;
            q.tgt      <= TGT_TUNER;
            q.scl_p    <= 1'b0;
            q.sda_p    <= 1'b0;
            q.div_high <= RST_DIV_HIGH;
            q.div_low  <= RST_DIV_LOW;
            q.control  <= RST_CONTROL;
            q.band     <= RST_BAND;
            q.aux      <= RST_AUX;
            q.if_sw    <= RST_IF_SWITCHING;
            q.if_adj   <= RST_IF_ADJUST;
            q.if_dat   <= RST_IF_DATA;
            q.por      <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state flops
    assign sda_out             = q.sda_o;
    assign sda_oe              = q.sda_oe;
    assign divider_ratio       = {q.div_high[5:0], q.div_low};
    assign pump_current_select = q.control[CTRL_CP_BIT];
    assign test_mode_bits      = q.control[CTRL_TEST_MSB:CTRL_TEST_LSB];
    assign step_size_select    = q.control[CTRL_RS_MSB:CTRL_RS_LSB];
    assign pll_disable         = q.control[CTRL_OS_BIT];
    assign band_port_bits      = q.band;
    assign band_decode         = q.band_dec;
    assign agc_time_select     = q.aux[AUX_ATC_BIT];
    assign agc_takeover_level  = q.aux[AUX_AL_MSB:AUX_AL_LSB];
    assign if_switching        = q.if_sw;
    assign if_adjust           = q.if_adj;
    assign if_data             = q.if_dat;
    assign lock_indicator      = q.lock;
    assign power_up_flag       = q.por;
endmodule

/* File: hw/tvf_pkg.sv */
// tvf package: constants, field layouts, carrier structs and state types
package tvf_pkg;

    // clock and lock reference timing
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned REF_PERIOD_NS  = 128000;   // 7.8125 kHz reference
    localparam int unsigned REF_CYC        = REF_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  LOCK_PERIODS   = 4'h8;

    // slave addresses
    localparam logic [7:0]  TUNER_ADDR_BASE    = 8'hC0;
    localparam logic [1:0]  ADDR_SEL_FLOAT     = 2'h1;   // floating pin answers at C2
    localparam logic [7:0]  IF_ADDR_DEFAULT    = 8'h86;
    localparam logic [7:0]  IF_ADDR_ALTERNATE  = 8'h84;

    // IF subaddresses
    localparam logic [1:0]  IF_SUB_SWITCHING   = 2'h0;
    localparam logic [1:0]  IF_SUB_ADJUST      = 2'h1;
    localparam logic [1:0]  IF_SUB_DATA        = 2'h2;
    localparam int unsigned IF_SUB_FORBID_BIT  = 7;

    // tuner byte positions after the address byte
    localparam logic [2:0]  POS_DIV_HIGH       = 3'h0;
    localparam logic [2:0]  POS_DIV_LOW        = 3'h1;
    localparam logic [2:0]  POS_CONTROL        = 3'h2;
    localparam logic [2:0]  POS_BAND_OR_AUX    = 3'h3;
    localparam logic [2:0]  POS_DONE           = 3'h4;

    // control byte fields
    localparam int unsigned CTRL_CP_BIT        = 6;
    localparam int unsigned CTRL_TEST_MSB      = 5;
    localparam int unsigned CTRL_TEST_LSB      = 3;
    localparam int unsigned CTRL_RS_MSB        = 2;
    localparam int unsigned CTRL_RS_LSB        = 1;
    localparam int unsigned CTRL_OS_BIT        = 0;
    localparam logic [2:0]  TEST_NORMAL        = 3'h1;
    localparam logic [2:0]  TEST_AUX_FOLLOWS   = 3'h3;

    // auxiliary byte fields
    localparam int unsigned AUX_ATC_BIT        = 7;
    localparam int unsigned AUX_AL_MSB         = 6;
    localparam int unsigned AUX_AL_LSB         = 4;

    // band select byte fields
    localparam int unsigned BAND_LOW_BIT       = 0;
    localparam int unsigned BAND_MID_BIT       = 1;
    localparam int unsigned BAND_HIGH_BIT      = 2;
    localparam int unsigned BAND_FM_A_BIT      = 3;
    localparam int unsigned BAND_FM_B_BIT      = 4;
    localparam int unsigned BAND_MONO_BIT      = 6;

    // status byte values
    localparam logic [1:0]  STATUS_ONES        = 2'h3;
    localparam logic [2:0]  STEREO_IND_STEREO  = 3'h4;
    localparam logic [2:0]  STEREO_IND_MONO    = 3'h0;

    // values after reset
    localparam logic [7:0]  RST_DIV_HIGH       = 8'h00;
    localparam logic [7:0]  RST_DIV_LOW        = 8'h00;
    localparam logic [7:0]  RST_CONTROL        = 8'hCE;  // high pump, normal test mode, 62.5 kHz
    localparam logic [7:0]  RST_BAND           = 8'h00;
    localparam logic [7:0]  RST_AUX            = 8'h20;  // takeover 010, 2 s time constant
    localparam logic [7:0]  RST_IF_SWITCHING   = 8'h00;
    localparam logic [7:0]  RST_IF_ADJUST      = 8'h10;  // takeover field 10000
    localparam logic [7:0]  RST_IF_DATA        = 8'h00;

    typedef struct packed {
        logic       l_prime_sound;
        logic       fm_high_sens;
        logic       force_mute;
        logic [1:0] modulation;      // 00 positive, 10 negative, x1 FM radio
        logic       qss_mode;
        logic       fm_out_mute;
        logic       trap_bypass;     // low keeps the sound trap active
    } tvf_if_switch_s;

    typedef struct packed {
        logic       gain_minus6;
        logic       deemph_50us;     // low selects 75 us
        logic       deemph_en;
        logic [4:0] takeover;
    } tvf_if_adjust_s;

    typedef struct packed {
        logic       vif_agc_on;
        logic       l_pll_gating;
        logic       if_gain_min;
        logic [2:0] vif_freq;        // 000 58.75, 001 45.75, 010 38.9, 100 33.9 MHz
        logic [1:0] sound_carrier;   // 4.5, 5.5, 6.0, 6.5 MHz
    } tvf_if_data_s;

    typedef struct packed {
        logic tv_low;
        logic tv_mid;
        logic tv_high;
        logic fm_band;
        logic fm_mono;
    } tvf_band_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_TX_ACK
    } tvf_state_e;

    typedef enum logic {
        TGT_TUNER, TGT_IF
    } tvf_target_e;

    typedef struct packed {
        tvf_state_e     st;
        tvf_target_e    tgt;
        logic           rw;
        logic           scl_p;
        logic           sda_p;
        logic [7:0]     sh;
        logic [3:0]     cnt;
        logic [2:0]     pos;
        logic [1:0]     ptr;
        logic           m_ack;
        logic           sda_oe;
        logic           sda_o;
        logic [7:0]     div_high;
        logic [7:0]     div_low;
        logic [7:0]     control;
        logic [7:0]     band;
        logic [7:0]     aux;
        tvf_band_s      band_dec;
        tvf_if_switch_s if_sw;
        tvf_if_adjust_s if_adj;
        tvf_if_data_s   if_dat;
        logic           por;
        logic [10:0]    ref_cnt;
        logic [3:0]     lock_cnt;
        logic           lock;
    } tvf_state_s;

endpackage

/* File: hw/tvf_sync.sv */
// tvf two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module tvf_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q_sync
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            q_sync <= '0;
        end else begin
            meta_q <= d_async;
            q_sync <= meta_q;
        end
    end
endmodule

/* File: tb/tvf_i2c_master.sv */
// I2C bus master model for the tuner and IF register bank, 800 ns per bit
`timescale 1ns/100ps
module tvf_i2c_master (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    // released lines idle high through the pull-up
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // quarter of a bit time
    task automatic hq();
        repeat (2) @(negedge mclk);
    endtask
    // start, also repeated start from clock low
    task automatic start();
        sda_m = 1'b1;
        hq();
        scl = 1'b1;
        hq();
        sda_m = 1'b0;
        hq();
        scl = 1'b0;
        hq();
    endtask
    // stop, clock then stands still high
    task automatic stop();
        sda_m = 1'b0;
        hq();
        scl = 1'b1;
        hq();
        sda_m = 1'b1;
        hq();
    endtask
    // eight bits msb first, ninth bit is the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i > 0) ? d[i-1] : mack;
            hq();
            scl = 1'b1;
            hq();
            s = sda;
            hq();
            scl = 1'b0;
            hq();
            if (i > 0) r[i-1] = s;
        end
        ack = ~s;
    endtask
endmodule

/* File: tb/tvf_i2c_regs_chk.sv */
// assertions on the ports of the register bank
`timescale 1ns/100ps
module tvf_i2c_regs_chk
    import tvf_pkg::*;
(
    input wire logic           mclk,
    input wire logic           resetn,
    input wire logic           pll_phase_locked,
    input wire logic           sda_oe,
    input wire logic [13:0]    divider_ratio,
    input wire logic [7:0]     band_port_bits,
    input wire tvf_band_s      band_decode,
    input wire logic [2:0]     agc_takeover_level,
    input wire tvf_if_adjust_s if_adjust,
    input wire logic           lock_indicator,
    input wire logic           power_up_flag
);
    localparam int LOCK_MIN = 8960;
    logic [15:0] run_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // cycles the raw lock input has stayed high
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run_q <= 16'h0;
        end else begin
            run_q <= !pll_phase_locked ? 16'h0 : ((run_q == 16'hFFFF) ? run_q : run_q + 16'h1);
        end
    end
    property p_reset_top;
        $rose(resetn) |-> agc_takeover_level == 3'h2 && power_up_flag;
    endproperty
    a_reset_top: assert property (p_reset_top) else $error("bad takeover or power-up after reset");
    property p_reset_adj;
        $rose(resetn) |-> if_adjust == 8'h10;
    endproperty
    a_reset_adj: assert property (p_reset_adj) else $error("bad adjust value after reset");
    property p_lock_time;
        $rose(lock_indicator) |-> run_q >= LOCK_MIN;
    endproperty
    a_lock_time: assert property (p_lock_time) else $error("lock flag raised too early");
    property p_lock_drop;
        !pll_phase_locked [*5] |-> !lock_indicator;
    endproperty
    a_lock_drop: assert property (p_lock_drop) else $error("lock flag kept without lock");
    property p_por_sticky;
        !power_up_flag |=> !power_up_flag;
    endproperty
    a_por_sticky: assert property (p_por_sticky) else $error("power-up flag set again");
    property p_band_dec;
        band_decode.fm_band == (band_port_bits[4] & band_port_bits[3] & band_port_bits[0])
            && band_decode.fm_mono == (band_decode.fm_band & band_port_bits[6]);
    endproperty
    a_band_dec: assert property (p_band_dec) else $error("band decode mismatch");
    property p_ack_stands;
        $rose(sda_oe) |-> sda_oe [*5];
    endproperty
    a_ack_stands: assert property (p_ack_stands) else $error("data pull too short");
    property p_commit;
        $changed(divider_ratio[13:8]) |-> $stable(divider_ratio[7:0]);
    endproperty
    a_commit: assert property (p_commit) else $error("two divider bytes committed at once");
endmodule
bind tvf_i2c_regs tvf_i2c_regs_chk i_chk (.*);

/* File: tb/tvf_i2c_regs_test.sv */
// self-checking bench for the tuner and IF register bank
`timescale 1ns/100ps
module tvf_i2c_regs_test
    import tvf_pkg::*;
;
    logic           mclk = 1'b0;
    logic           resetn = 1'b0;
    logic           scl_in, sda_m, sda_out, sda_oe, pll_disable, ack;
    logic [1:0]     address_select_bits = 2'h1;
    logic           address_select_float = 1'b0, if_address_alt = 1'b0;
    logic           pll_phase_locked = 1'b0, agc_active = 1'b0, fm_stereo_detect = 1'b0;
    logic [13:0]    divider_ratio;
    logic [1:0]     step_size_select;
    logic [2:0]     test_mode_bits, agc_takeover_level;
    logic           pump_current_select, agc_time_select, lock_indicator, power_up_flag;
    logic [7:0]     band_port_bits, rd;
    tvf_band_s      band_decode;
    tvf_if_switch_s if_switching;
    tvf_if_adjust_s if_adjust;
    tvf_if_data_s   if_data;
    wire            sda_in = sda_oe ? 1'b0 : sda_m;
    int             n_mismatch = 0, n_checks = 0;
    logic [2:0]     lv [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    logic [2:0]     vf [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    // 10 MHz clock
    always #50 mclk = ~mclk;
    tvf_i2c_regs i_dut (.*);
    tvf_i2c_master i_mst (.mclk(mclk), .sda(sda_in), .scl(scl_in), .sda_m(sda_m));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one byte from the master, acknowledge compared
    task automatic wb(input logic [7:0] d, input logic exp_ack);
        i_mst.xfer(d, 1'b1, rd, ack);
        chk("ack", 16'(exp_ack), 16'(ack));
    endtask
    // complete tuner write at address C2
    task automatic tw(input logic [7:0] h, input logic [7:0] l, input logic [7:0] c, input logic [7:0] b);
        i_mst.start();
        wb(8'hC2, 1'b1);
        wb(h, 1'b1);
        wb(l, 1'b1);
        wb(c, 1'b1);
        wb(b, 1'b1);
        i_mst.stop();
    endtask
    // one status byte, ended by a no-acknowledge
    task automatic rs(input logic [7:0] e);
        i_mst.start();
        wb(8'hC3, 1'b1);
        i_mst.xfer(8'hFF, 1'b1, rd, ack);
        i_mst.stop();
        chk("status", 16'(e), 16'(rd));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        repeat (6) @(negedge mclk);
        chk("takeover", 16'h2, 16'(agc_takeover_level));
        chk("por", 16'h1, 16'(power_up_flag));
        chk("ctrl", 16'h4E, 16'({pump_current_select, test_mode_bits, step_size_select, pll_disable}));
        chk("sda_out", 16'h0, 16'(sda_out));
        for (int i = 0; i < 4; i++) begin
            tw(8'h1F, 8'hE2, {5'h19, i[1:0], 1'b0}, 8'h44);
            chk("step", 16'(i[1:0]), 16'(step_size_select));
            chk("tv_high", 16'h2, 16'({band_decode.tv_high, band_decode.fm_band}));
        end
        tw(8'h1F, 8'hE2, 8'h8A, 8'h59);
        chk("divider", 16'h1FE2, 16'(divider_ratio));
        chk("pump", 16'h0, 16'(pump_current_select));
        chk("fm", 16'h6, 16'({band_decode.fm_band, band_decode.fm_mono, band_decode.tv_low}));
        for (int i = 0; i < 4; i++) begin
            address_select_bits = i[1:0];
            i_mst.start();
            wb(8'hC0 + 8'(2 * ((i + 1) % 4)), 1'b0);
            i_mst.start();
            wb(8'hC0 + 8'(2 * i), 1'b1);
            wb(8'(i), 1'b1);
            i_mst.stop();
            chk("divider", 16'({i[5:0], 8'hE2}), 16'(divider_ratio));
        end
        address_select_float = 1'b1;
        address_select_bits = 2'h0;
        i_mst.start();
        wb(8'hC0, 1'b0);
        i_mst.start();
        wb(8'hC2, 1'b1);
        i_mst.stop();
        address_select_float = 1'b0;
        address_select_bits = 2'h1;
        for (int i = 0; i < 5; i++) begin
            tw(8'h1F, 8'hE2, 8'hDE, {i[0], lv[i], 4'h0});
            chk("takeover", 16'(lv[i]), 16'(agc_takeover_level));
            chk("atc", 16'(i[0]), 16'(agc_time_select));
        end
        chk("band", 16'h59, 16'(band_port_bits));
        pll_phase_locked = 1'b1;
        agc_active = 1'b1;
        fm_stereo_detect = 1'b1;
        for (int i = 0; i < 12000 && lock_indicator !== 1'b1; i++) begin
            @(negedge mclk);
        end
        chk("lock", 16'h1, 16'(lock_indicator));
        if (lock_indicator !== 1'b1) begin
            end_sim();
        end
        rs(8'hFC);
        chk("por", 16'h0, 16'(power_up_flag));
        agc_active = 1'b0;
        fm_stereo_detect = 1'b0;
        repeat (4) @(negedge mclk);
        rs(8'h70);
        pll_phase_locked = 1'b0;
        repeat (6) @(negedge mclk);
        chk("lock", 16'h0, 16'(lock_indicator));
        i_mst.start();
        wb(8'h86, 1'b1);
        wb(8'h00, 1'b1);
        wb(8'h8E, 1'b1);
        wb(8'h50, 1'b1);
        wb(8'h6B, 1'b1);
        i_mst.stop();
        chk("if", 16'(8'h8E), 16'(if_switching));
        chk("if", 16'(8'h50), 16'(if_adjust));
        chk("if", 16'(8'h6B), 16'(if_data));
        if_address_alt = 1'b1;
        for (int k = 0; k < 4; k++) begin
            i_mst.start();
            wb(8'h84, 1'b1);
            wb(8'h02, 1'b1);
            wb({3'h2, vf[k], k[1:0]}, 1'b1);
            i_mst.stop();
            chk("if_data", 16'({3'h2, vf[k], k[1:0]}), 16'(if_data));
        end
        i_mst.start();
        wb(8'h86, 1'b0);
        i_mst.start();
        wb(8'h84, 1'b1);
        wb(8'h80, 1'b0);
        i_mst.stop();
        chk("if", 16'(8'h8E), 16'(if_switching));
        end_sim();
    end
endmodule
